//--- rtl/boot_sleep_algo_control.sv
// boot source selection, reset, algorithm toggle and sleep mode control
`timescale 1ns/100ps
`default_nettype none
module boot_sleep_algo_control #(
	parameter int ALGO_LOW_CYC = boot_sleep_pkg::ALGO_LOW_CYC,
	parameter int SLEEP_LOW_CYC = boot_sleep_pkg::SLEEP_LOW_CYC,
	parameter int WAKE_CYC = boot_sleep_pkg::WAKE_WINDOW_CYC,
	parameter int CLK_LOSS_CYC = boot_sleep_pkg::CLK_LOSS_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control pins
	input wire logic boot_source_select,
	input wire logic external_reset_low,
	input wire logic noise_algorithm_toggle,
	input wire logic low_power_toggle_pin,
	input wire logic ext_clk_sense,
	// preset codes from the low_speed_level_converter
	input wire logic [2:0] preset_config_pin,
	input wire logic [2:0] output_attenuation_pin,
	// serial eeprom loader
	input wire logic eeprom_load_done,
	input wire logic eeprom_load_ok,
	// i2c command handler
	input wire logic i2c_wake,
	input wire logic mode_cmd_valid,
	input wire logic [2:0] mode_cmd_code,
	input wire logic algo_cmd_valid,
	input wire logic algo_cmd_enable,
	// output channel routing
	input wire logic dmic_chan_sel,
	input wire logic aout_chan_sel,
	// boot status
	output logic core_reset_r,
	output logic spi_enable_r,
	output logic boot_from_eeprom_r,
	output logic rom_app_r,
	output logic boot_done_r,
	output logic host_download_ready_r,
	output logic [2:0] preset_code_r,
	output logic [2:0] atten_code_r,
	// mode and algorithm status
	output logic [2:0] op_mode_r,
	output logic sleep_active_r,
	output logic algo_enable_r,
	output logic dmic_processed_r,
	output logic aout_processed_r
);
	boot_sleep_pkg::boot_state_t boot_r;
	boot_sleep_pkg::boot_state_t boot_nxt;
	boot_sleep_pkg::mode_state_t mode_r;
	boot_sleep_pkg::mode_state_t mode_nxt;
	boot_sleep_pkg::mode_state_t resume_r;
	boot_sleep_pkg::sleep_cause_t cause_r;
	boot_sleep_pkg::sleep_cause_t cause_nxt;
	logic ext_rst_fire;
	logic algo_fire;
	logic sleep_fire;
	logic clk_ok;
	logic sys_rst;
	logic booted;
	logic awake_cmd;
	logic [31:0] por_cnt_r;
	logic [31:0] eep_cnt_r;
	logic [31:0] win_cnt_r;

	// external reset qualified by its minimum low width
	pin_low_timer #(.MIN_CYC(boot_sleep_pkg::EXT_RST_CYC)) u_ext_rst (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin(external_reset_low),
		.fire_r(ext_rst_fire)
	);

	// algorithm toggle pin; a low shorter than the minimum is ignored, so one long low toggles once
	pin_low_timer #(.MIN_CYC(ALGO_LOW_CYC)) u_algo_pin (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin(noise_algorithm_toggle),
		.fire_r(algo_fire)
	);

	// sleep toggle pin
	pin_low_timer #(.MIN_CYC(SLEEP_LOW_CYC)) u_sleep_pin (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin(low_power_toggle_pin),
		.fire_r(sleep_fire)
	);

	// external clock presence
	clock_presence_monitor #(.LOSS_CYC(CLK_LOSS_CYC)) u_clk_mon (
		.ref_clk(ref_clk),
		.rst(rst),
		.ext_clk_sense(ext_clk_sense),
		.clk_ok_r(clk_ok)
	);

	// either reset source restarts the whole power-on sequence
	assign sys_rst = rst || ext_rst_fire;
	assign booted = (boot_r == boot_sleep_pkg::B_RUN);
	assign awake_cmd = mode_cmd_valid && (mode_cmd_code == boot_sleep_pkg::MODE_ACTIVE
		|| mode_cmd_code == boot_sleep_pkg::MODE_BYPASS
		|| mode_cmd_code == boot_sleep_pkg::MODE_LINEOUT);

	// boot sequence next state
	always_comb begin
		boot_nxt = boot_r;
		case (boot_r)
			boot_sleep_pkg::B_RESET: begin
				if (por_cnt_r == 32'(boot_sleep_pkg::POR_HOLD_CYC - 1)) begin
					boot_nxt = boot_sleep_pkg::B_SAMPLE;
				end
			end
			boot_sleep_pkg::B_SAMPLE: begin
				// only a solid low skips the eeprom; the pad pull-up covers floating
				if (boot_source_select != 1'b0) begin
					boot_nxt = boot_sleep_pkg::B_EEPROM;
				end else begin
					boot_nxt = boot_sleep_pkg::B_ROM;
				end
			end
			boot_sleep_pkg::B_EEPROM: begin
				if (eeprom_load_done && eeprom_load_ok) begin
					boot_nxt = boot_sleep_pkg::B_RUN;
				end else if (eeprom_load_done
					|| eep_cnt_r == 32'(boot_sleep_pkg::EEPROM_WAIT_CYC - 1)) begin
					boot_nxt = boot_sleep_pkg::B_ROM;
				end
			end
			boot_sleep_pkg::B_ROM: boot_nxt = boot_sleep_pkg::B_RUN;
			boot_sleep_pkg::B_RUN: boot_nxt = boot_sleep_pkg::B_RUN;
			default: boot_nxt = boot_sleep_pkg::B_RESET;
		endcase
	end

	// boot state register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			boot_r <= boot_sleep_pkg::B_RESET;
		end else begin
			boot_r <= boot_nxt;
		end
	end

	// power-on hold and eeprom answer timers
	always_ff @(posedge ref_clk) begin
		if (sys_rst || boot_r != boot_sleep_pkg::B_RESET) begin
			por_cnt_r <= 32'h0;
		end else begin
			por_cnt_r <= por_cnt_r + 32'h1;
		end
		if (sys_rst || boot_r != boot_sleep_pkg::B_EEPROM) begin
			eep_cnt_r <= 32'h0;
		end else begin
			eep_cnt_r <= eep_cnt_r + 32'h1;
		end
	end

	// boot status outputs, all registered from the next boot state
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			core_reset_r <= 1'b1;
			spi_enable_r <= 1'b0;
			boot_done_r <= 1'b0;
			host_download_ready_r <= 1'b0;
		end else begin
			core_reset_r <= (boot_nxt == boot_sleep_pkg::B_RESET);
			spi_enable_r <= (boot_nxt == boot_sleep_pkg::B_EEPROM);
			boot_done_r <= (boot_nxt == boot_sleep_pkg::B_RUN);
			host_download_ready_r <= (boot_nxt == boot_sleep_pkg::B_RUN);
		end
	end

	// boot source result
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			boot_from_eeprom_r <= 1'b0;
			rom_app_r <= 1'b0;
		end else if (boot_r == boot_sleep_pkg::B_EEPROM && boot_nxt == boot_sleep_pkg::B_RUN) begin
			boot_from_eeprom_r <= 1'b1;
		end else if (boot_r == boot_sleep_pkg::B_ROM) begin
			rom_app_r <= 1'b1;
		end
	end

	// presets caught once per boot; later pin changes wait for a reboot
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			preset_code_r <= boot_sleep_pkg::PRESET_RST;
			atten_code_r <= boot_sleep_pkg::ATTEN_RST;
		end else if (boot_r == boot_sleep_pkg::B_SAMPLE) begin
			preset_code_r <= preset_config_pin;
			atten_code_r <= output_attenuation_pin;
		end
	end

	// mode next state; the pin is ignored until boot ends, so eeprom search is safe
	always_comb begin
		mode_nxt = mode_r;
		cause_nxt = cause_r;
		case (mode_r)
			boot_sleep_pkg::M_ACTIVE, boot_sleep_pkg::M_BYPASS, boot_sleep_pkg::M_LINEOUT: begin
				if (booted && sleep_fire) begin
					mode_nxt = boot_sleep_pkg::M_SLEEP;
					cause_nxt = boot_sleep_pkg::C_PIN;
				end else if (mode_cmd_valid && mode_cmd_code == boot_sleep_pkg::MODE_SLEEP) begin
					mode_nxt = boot_sleep_pkg::M_SLEEP;
					cause_nxt = boot_sleep_pkg::C_CMD;
				end else if (awake_cmd) begin
					mode_nxt = boot_sleep_pkg::mode_state_t'(mode_cmd_code);
				end else if (booted && !clk_ok && mode_r != boot_sleep_pkg::M_LINEOUT) begin
					mode_nxt = boot_sleep_pkg::M_SLEEP;
					cause_nxt = boot_sleep_pkg::C_CLK;
				end
			end
			boot_sleep_pkg::M_SLEEP: begin
				case (cause_r)
					boot_sleep_pkg::C_PIN: begin
						if (sleep_fire) begin
							mode_nxt = boot_sleep_pkg::M_ACTIVE;
							cause_nxt = boot_sleep_pkg::C_NONE;
						end
					end
					boot_sleep_pkg::C_CMD: begin
						if (i2c_wake) begin
							mode_nxt = boot_sleep_pkg::M_STANDBY;
						end
					end
					boot_sleep_pkg::C_CLK: begin
						if (clk_ok) begin
							mode_nxt = resume_r;
							cause_nxt = boot_sleep_pkg::C_NONE;
						end
					end
					default: cause_nxt = boot_sleep_pkg::C_NONE;
				endcase
			end
			boot_sleep_pkg::M_STANDBY: begin
				if (awake_cmd) begin
					mode_nxt = boot_sleep_pkg::mode_state_t'(mode_cmd_code);
					cause_nxt = boot_sleep_pkg::C_NONE;
				end else if (win_cnt_r == 32'(WAKE_CYC - 1)) begin
					mode_nxt = boot_sleep_pkg::M_SLEEP;
				end
			end
			default: mode_nxt = boot_sleep_pkg::M_ACTIVE;
		endcase
	end

	// mode and sleep cause registers; reset always lands in Active
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_r <= boot_sleep_pkg::M_ACTIVE;
			cause_r <= boot_sleep_pkg::C_NONE;
		end else begin
			mode_r <= mode_nxt;
			cause_r <= cause_nxt;
		end
	end

	// mode to resume after clock loss
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			resume_r <= boot_sleep_pkg::M_ACTIVE;
		end else if (cause_nxt == boot_sleep_pkg::C_CLK && cause_r != boot_sleep_pkg::C_CLK) begin
			resume_r <= mode_r;
		end
	end

	// wake window, counting only while in standby
	always_ff @(posedge ref_clk) begin
		if (sys_rst || mode_r != boot_sleep_pkg::M_STANDBY) begin
			win_cnt_r <= 32'h0;
		end else begin
			win_cnt_r <= win_cnt_r + 32'h1;
		end
	end

	// mode status outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			op_mode_r <= boot_sleep_pkg::MODE_ACTIVE;
			sleep_active_r <= 1'b0;
		end else begin
			op_mode_r <= 3'(mode_nxt);
			sleep_active_r <= (mode_nxt == boot_sleep_pkg::M_SLEEP);
		end
	end

	// algorithm state; a command in the same cycle as a pin event wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			algo_enable_r <= boot_sleep_pkg::ALGO_EN_RST;
		end else if (booted && algo_cmd_valid) begin
			algo_enable_r <= algo_cmd_enable;
		end else if (booted && algo_fire) begin
			algo_enable_r <= !algo_enable_r;
		end
	end

	// channel 0 is processed while enabled; each output picks its channel
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dmic_processed_r <= boot_sleep_pkg::ALGO_EN_RST;
			aout_processed_r <= boot_sleep_pkg::ALGO_EN_RST;
		end else begin
			dmic_processed_r <= algo_enable_r ^ dmic_chan_sel;
			aout_processed_r <= algo_enable_r ^ aout_chan_sel;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_ROM_SKIP: assert property (boot_r == boot_sleep_pkg::B_SAMPLE
		&& !boot_source_select |=> boot_r == boot_sleep_pkg::B_ROM ##1 rom_app_r)
		else $error("low boot select did not load rom");
	AST_EEPROM_FALLBACK: assert property (boot_r == boot_sleep_pkg::B_EEPROM
		&& eeprom_load_done && !eeprom_load_ok |=> boot_r == boot_sleep_pkg::B_ROM ##1 booted)
		else $error("bad eeprom did not fall back to rom");
	AST_SPI_WINDOW: assert property (spi_enable_r
		|-> boot_r == boot_sleep_pkg::B_EEPROM && !boot_done_r)
		else $error("spi enabled outside eeprom search");
	AST_PRESET_HELD: assert property (booted && $past(booted)
		|-> $stable(preset_code_r) && $stable(atten_code_r))
		else $error("preset changed after boot");
	AST_EXT_RESET: assert property (external_reset_low
		##1 !external_reset_low [*8] ##1 !external_reset_low [*2] |-> ##[1:3] core_reset_r)
		else $error("long external reset did not restart");
	AST_ALGO_TOGGLE: assert property (booted && algo_fire && !algo_cmd_valid
		|=> algo_enable_r != $past(algo_enable_r))
		else $error("algorithm did not toggle");
	AST_CHANNEL_SWAP: assert property (!dmic_chan_sel && $past(!dmic_chan_sel)
		&& !$past(sys_rst) |-> dmic_processed_r == $past(algo_enable_r))
		else $error("channel 0 does not follow algorithm state");
	AST_PIN_SLEEP_HOLD: assert property (mode_r == boot_sleep_pkg::M_SLEEP
		&& cause_r == boot_sleep_pkg::C_PIN && !sleep_fire
		|=> mode_r == boot_sleep_pkg::M_SLEEP)
		else $error("pin sleep left without pin event");
	AST_PIN_WAKE_ACTIVE: assert property (mode_r == boot_sleep_pkg::M_SLEEP
		&& cause_r == boot_sleep_pkg::C_PIN && sleep_fire
		|=> mode_r == boot_sleep_pkg::M_ACTIVE && op_mode_r == boot_sleep_pkg::MODE_ACTIVE)
		else $error("pin wake did not reach active");
	AST_WAKE_TIMEOUT: assert property (mode_r == boot_sleep_pkg::M_STANDBY
		&& !awake_cmd && win_cnt_r == 32'(WAKE_CYC - 1) |=> sleep_active_r)
		else $error("standby outlived the wake window");
	AST_CLK_LOSS_SLEEP: assert property (booted && !clk_ok && !sleep_fire
		&& !mode_cmd_valid && (mode_r == boot_sleep_pkg::M_ACTIVE
		|| mode_r == boot_sleep_pkg::M_BYPASS)
		|=> mode_r == boot_sleep_pkg::M_SLEEP && cause_r == boot_sleep_pkg::C_CLK)
		else $error("clock loss did not force sleep");
	AST_CLK_RESUME: assert property (mode_r == boot_sleep_pkg::M_SLEEP
		&& cause_r == boot_sleep_pkg::C_CLK |-> !clk_ok or ##1 mode_r == $past(resume_r))
		else $error("clock-loss sleep exit wrong");

	COV_EEPROM_BOOT: cover property (boot_r == boot_sleep_pkg::B_EEPROM ##1 boot_from_eeprom_r);
	COV_I2C_WAKE: cover property (mode_r == boot_sleep_pkg::M_STANDBY ##1 awake_cmd);
	COV_PIN_SLEEP: cover property (cause_r == boot_sleep_pkg::C_PIN ##1 sleep_fire);
	COV_CLK_LOSS: cover property (cause_r == boot_sleep_pkg::C_CLK ##1 clk_ok);
endmodule : boot_sleep_algo_control
`default_nettype wire

//--- rtl/boot_sleep_pkg.sv
// constants, encodings and timing for the boot, sleep and algorithm control block
// Summary of operation
// - After power-on reset run the ROM application with default configuration.
// - Boot select high or floating enables SPI and tries an EEPROM load.
// - No EEPROM answer or bad content falls back to ROM with pin presets.
// - Boot select low skips EEPROM and loads ROM with pin presets.
// - Preset and attenuation levels are sampled only at boot, then held.
// - After default boot the host may download or reconfigure over I2C.
// - External reset held low at least 100 ns forces full power-on reset.
// - Algorithm state toggles once per low level lasting at least 10 ms.
// - Algorithm on: channel 0 processed, channel 1 raw; off swaps them.
// - Digital mic and analog outputs each pick either channel independently.
// - Sleep and awake toggle once per sleep pin low of at least 20 ms.
// - Sleep entered by pin ends only by another pin toggle or reset.
// - Leaving sleep by the pin always lands in Active mode.
// - Mode command enters or leaves sleep; then only command or reset wakes.
// - Without a completed wake procedure within about one second, sleep again.
// - Invalid conditions such as a stopped clock force sleep as fail-safe; the code sleeps only on a stopped clock, from Active or Bypass after boot.
// - I2C wake goes to Standby, awaiting a mode command or returning to sleep.
// - Clock-loss sleep from Active or Bypass ends on clock return or reset.
package boot_sleep_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 10;
	// timing figures in their own units
	localparam int EXT_RST_MIN_NS = 100;
	localparam int ALGO_LOW_MS = 10;
	localparam int SLEEP_LOW_MS = 20;
	localparam int WAKE_WINDOW_S = 1;
	// derived cycle counts; only the external reset minimum rounds up, the low times and the window round down
	localparam int EXT_RST_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALGO_LOW_CYC = (ALGO_LOW_MS * 1000000) / CLK_PERIOD_NS;
	localparam int SLEEP_LOW_CYC = (SLEEP_LOW_MS * 1000000) / CLK_PERIOD_NS;
	localparam int WAKE_WINDOW_CYC = (WAKE_WINDOW_S * 1000000000) / CLK_PERIOD_NS;
	// internal hold and timeout counts
	localparam int POR_HOLD_CYC = 16;
	localparam int EEPROM_WAIT_CYC = 4096;
	localparam int CLK_LOSS_CYC = 64;
	// mode codes, shared by the mode command and the mode status
	localparam logic [2:0] MODE_ACTIVE = 3'h0;
	localparam logic [2:0] MODE_BYPASS = 3'h1;
	localparam logic [2:0] MODE_LINEOUT = 3'h2;
	localparam logic [2:0] MODE_SLEEP = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h4;
	// values after reset
	localparam logic [2:0] PRESET_RST = 3'h0;
	localparam logic [2:0] ATTEN_RST = 3'h0;
	localparam logic ALGO_EN_RST = 1'b1;
	typedef enum {B_RESET, B_SAMPLE, B_EEPROM, B_ROM, B_RUN} boot_state_t;
	typedef enum {M_ACTIVE, M_BYPASS, M_LINEOUT, M_SLEEP, M_STANDBY} mode_state_t;
	typedef enum {C_NONE, C_PIN, C_CMD, C_CLK} sleep_cause_t;
endpackage : boot_sleep_pkg

//--- rtl/pin_low_timer.sv
// synchroniser and low-time qualifier for one control pin
`timescale 1ns/100ps
`default_nettype none
module pin_low_timer #(
	parameter int MIN_CYC = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// pin and qualified event
	input wire logic pin,
	output logic fire_r
);
	logic meta_r;
	logic sync_r;
	logic [31:0] cnt_r;

	// idle level is high, so a reset never looks like a falling pin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
		end
	end

	// low time counter saturates so one low interval gives one event
	always_ff @(posedge ref_clk) begin
		if (rst || sync_r) begin
			cnt_r <= 32'h0;
		end else if (cnt_r != 32'(MIN_CYC)) begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	// fires in the cycle the low time reaches its minimum
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fire_r <= 1'b0;
		end else begin
			fire_r <= !sync_r && (cnt_r == 32'(MIN_CYC - 1));
		end
	end
endmodule : pin_low_timer
`default_nettype wire

//--- rtl/clock_presence_monitor.sv
// watches the sampled external clock and flags when it stops
`timescale 1ns/100ps
`default_nettype none
module clock_presence_monitor #(
	parameter int LOSS_CYC = 64
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sampled external clock and result
	input wire logic ext_clk_sense,
	output logic clk_ok_r
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic [31:0] gap_r;

	// two-stage sync plus one more for the edge compare
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= ext_clk_sense;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// cycles since the last seen edge, saturating
	always_ff @(posedge ref_clk) begin
		if (rst || (s2_r ^ s3_r)) begin
			gap_r <= 32'h0;
		end else if (gap_r != 32'(LOSS_CYC)) begin
			gap_r <= gap_r + 32'h1;
		end
	end

	// presence assumed at reset so boot never starts asleep
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_ok_r <= 1'b1;
		end else begin
			clk_ok_r <= (gap_r != 32'(LOSS_CYC));
		end
	end
endmodule : clock_presence_monitor
`default_nettype wire

//--- dv/host_pin_model.sv
// host controller model that drives the algorithm and sleep toggle pins
`timescale 1ns/100ps
`default_nettype none
module host_pin_model (
	// clock and boot status
	input wire logic ref_clk,
	input wire logic boot_done,
	// driven pins
	output logic algo_pin,
	output logic sleep_pin
);
	// both pins idle high as clean logic levels, never bouncing
	initial begin
		algo_pin = 1'b1;
		sleep_pin = 1'b1;
	end
	// hold one pin low for n cycles; the sleep pin stays released while the boot search runs
	task automatic press(input logic which, input int n);
		wait (boot_done === 1'b1);
		if (which) begin
			sleep_pin = 1'b0;
		end else begin
			algo_pin = 1'b0;
		end
		repeat (n) @(posedge ref_clk);
		#1;
		algo_pin = 1'b1;
		sleep_pin = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : press
endmodule : host_pin_model
`default_nettype wire

//--- dv/boot_sleep_algo_control_bench.sv
// self-checking bench for the boot, sleep and algorithm control block
`timescale 1ns/100ps
`default_nettype none
module boot_sleep_algo_control_bench;
	// shortened counts so the run stays brief
	localparam int A_CYC = 20;
	localparam int S_CYC = 30;
	localparam int W_CYC = 50;
	localparam int L_CYC = 16;
	logic ref_clk, rst, boot_sel, ext_rst_n, algo_pin, sleep_pin, clk_sense, clk_run;
	logic ee_done, ee_ok, i2c_wake, cmd_valid, acmd_valid, acmd_en, dmic_sel, aout_sel;
	logic core_reset, spi_en, from_ee, rom_app, boot_done, dl_ready, sleep_act, algo_en;
	logic dmic_proc, aout_proc, exp_algo;
	logic [2:0] preset, atten, cmd_code, preset_q, atten_q, op_mode;
	logic [31:0] seed;
	int n_errors, compares, cycles;

	boot_sleep_algo_control #(.ALGO_LOW_CYC(A_CYC), .SLEEP_LOW_CYC(S_CYC), .WAKE_CYC(W_CYC),
		.CLK_LOSS_CYC(L_CYC)) dut (.ref_clk(ref_clk), .rst(rst),
		.boot_source_select(boot_sel), .external_reset_low(ext_rst_n),
		.noise_algorithm_toggle(algo_pin), .low_power_toggle_pin(sleep_pin),
		.ext_clk_sense(clk_sense), .preset_config_pin(preset), .output_attenuation_pin(atten),
		.eeprom_load_done(ee_done), .eeprom_load_ok(ee_ok), .i2c_wake(i2c_wake),
		.mode_cmd_valid(cmd_valid), .mode_cmd_code(cmd_code), .algo_cmd_valid(acmd_valid),
		.algo_cmd_enable(acmd_en), .dmic_chan_sel(dmic_sel), .aout_chan_sel(aout_sel),
		.core_reset_r(core_reset), .spi_enable_r(spi_en), .boot_from_eeprom_r(from_ee),
		.rom_app_r(rom_app), .boot_done_r(boot_done), .host_download_ready_r(dl_ready),
		.preset_code_r(preset_q), .atten_code_r(atten_q), .op_mode_r(op_mode),
		.sleep_active_r(sleep_act), .algo_enable_r(algo_en), .dmic_processed_r(dmic_proc),
		.aout_processed_r(aout_proc));
	host_pin_model host (.ref_clk(ref_clk), .boot_done(boot_done), .algo_pin(algo_pin),
		.sleep_pin(sleep_pin));

	// clock and the external clock seen by the loss monitor
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (clk_run) clk_sense <= ~clk_sense;
	end
	// hang guard; the run needs well under a tenth of this
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// channel 0 carries the processed signal while the algorithm is on
	function automatic logic proc_exp(input logic sel, input logic alg);
		return sel ? ~alg : alg;
	endfunction : proc_exp
	task automatic chk_algo();
		{dmic_sel, aout_sel} = 2'(xs());
		cyc(2);
		chk("algo_enable", 3'(algo_en), 3'(exp_algo));
		chk("dmic_processed", 3'(dmic_proc), 3'(proc_exp(dmic_sel, exp_algo)));
		chk("aout_processed", 3'(aout_proc), 3'(proc_exp(aout_sel, exp_algo)));
	endtask : chk_algo
	task automatic cmd(input logic [2:0] c);
		cmd_code = c;
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
		cyc(2);
	endtask : cmd
	task automatic wake();
		i2c_wake = 1'b1;
		cyc(1);
		i2c_wake = 1'b0;
		cyc(2);
	endtask : wake
	// one boot: reset by pin or rst, random straps, optional eeprom answer
	task automatic boot(input logic by_pin, input logic sel, input logic ok);
		logic [2:0] p;
		logic [2:0] a;
		int i;
		p = 3'(xs());
		a = 3'(xs());
		preset = p;
		atten = a;
		boot_sel = sel;
		if (by_pin) begin
			ext_rst_n = 1'b0;
			cyc(16);
			chk("core_reset", 3'(core_reset), 3'h1);
			ext_rst_n = 1'b1;
		end else begin
			rst = 1'b1;
			cyc(12);
			rst = 1'b0;
		end
		for (i = 0; i < 60 && core_reset !== 1'b0; i++) cyc(1);
		cyc(2);
		chk("spi_enable", 3'(spi_en), 3'(sel));
		preset = ~p;
		atten = ~a;
		// only the loader answers; the bench drives nothing onto the shared pins
		if (sel) begin
			cyc(3);
			ee_done = 1'b1;
			ee_ok = ok;
			cyc(1);
			ee_done = 1'b0;
		end
		for (i = 0; i < 20 && boot_done !== 1'b1; i++) cyc(1);
		cyc(2);
		chk("boot_done", 3'(boot_done), 3'h1);
		chk("rom_app", 3'(rom_app), 3'(!(sel && ok)));
		chk("boot_from_eeprom", 3'(from_ee), 3'(sel && ok));
		chk("preset_code", preset_q, p);
		chk("atten_code", atten_q, a);
		chk("download_ready", 3'(dl_ready), 3'h1);
		chk("spi_after_boot", 3'(spi_en), 3'h0);
		chk("mode_after_boot", op_mode, boot_sleep_pkg::MODE_ACTIVE);
		exp_algo = 1'b1;
	endtask : boot
	task automatic tally_and_finish();
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		{rst, ext_rst_n, clk_run} = 3'h7;
		{boot_sel, clk_sense, ee_done, ee_ok, i2c_wake, cmd_valid, acmd_valid} = 7'h00;
		{acmd_en, dmic_sel, aout_sel} = 3'h0;
		{preset, atten, cmd_code} = 9'h000;
		seed = 32'ha67b;
		boot(1'b0, 1'b0, 1'b0);
		// short low is refused, full low toggles, command sets the state directly
		chk_algo();
		host.press(1'b0, A_CYC - 4);
		chk_algo();
		host.press(1'b0, A_CYC + 6);
		exp_algo = ~exp_algo;
		chk_algo();
		acmd_en = ~exp_algo;
		acmd_valid = 1'b1;
		cyc(1);
		acmd_valid = 1'b0;
		exp_algo = ~exp_algo;
		chk_algo();
		// pin sleep ignores i2c wake and commands, next pin low returns to active
		host.press(1'b1, S_CYC + 6);
		chk("pin_sleep", op_mode, boot_sleep_pkg::MODE_SLEEP);
		chk("sleep_active", 3'(sleep_act), 3'h1);
		wake();
		cmd(boot_sleep_pkg::MODE_BYPASS);
		chk("pin_sleep_held", op_mode, boot_sleep_pkg::MODE_SLEEP);
		host.press(1'b1, S_CYC + 6);
		chk("pin_wake", op_mode, boot_sleep_pkg::MODE_ACTIVE);
		// command sleep: pin ignored, wake to standby, window lapse, then bypass
		cmd(boot_sleep_pkg::MODE_SLEEP);
		chk("cmd_sleep", op_mode, boot_sleep_pkg::MODE_SLEEP);
		host.press(1'b1, S_CYC + 6);
		chk("cmd_sleep_held", op_mode, boot_sleep_pkg::MODE_SLEEP);
		wake();
		chk("standby", op_mode, boot_sleep_pkg::MODE_STANDBY);
		cyc(W_CYC + 5);
		chk("window_lapse", op_mode, boot_sleep_pkg::MODE_SLEEP);
		wake();
		cmd(boot_sleep_pkg::MODE_BYPASS);
		chk("cmd_wake", op_mode, boot_sleep_pkg::MODE_BYPASS);
		// stopped clock forces sleep, its return resumes bypass
		clk_run = 1'b0;
		cyc(L_CYC + 8);
		chk("clock_loss", op_mode, boot_sleep_pkg::MODE_SLEEP);
		clk_run = 1'b1;
		cyc(8);
		chk("clock_back", op_mode, boot_sleep_pkg::MODE_BYPASS);
		// line-out runs on its own clock, so a stopped clock leaves it alone
		cmd(boot_sleep_pkg::MODE_LINEOUT);
		chk("cmd_lineout", op_mode, boot_sleep_pkg::MODE_LINEOUT);
		clk_run = 1'b0;
		cyc(L_CYC + 8);
		chk("lineout_no_clk", op_mode, boot_sleep_pkg::MODE_LINEOUT);
		clk_run = 1'b1;
		cyc(8);
		// reboots: bad eeprom falls back, good eeprom loads, low select goes to rom
		boot(1'b1, 1'b1, 1'b0);
		boot(1'b0, 1'b1, 1'b1);
		boot(1'b1, 1'b0, 1'b1);
		tally_and_finish();
	end
endmodule : boot_sleep_algo_control_bench
`default_nettype wire
